/* File: rtl/fieldbus_register_access.sv */
`timescale 1ns/10ps
`include "fieldbus_register_access_params.svh"
module fieldbus_register_access (
    input wire logic clk, // 20 MHz clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic [5:0] peer_node_selector, // node whose global data is consumed
    input wire logic [6:0] io_size_in, // global input words
    input wire logic [6:0] io_size_out, // global output words
    input wire logic host_busy, // host side busy
    input wire logic token_pass, // pulse: token reached this node
    output logic gd_valid, // global exchange in progress
    output logic [5:0] gd_peer, // peer node of exchange
    output logic [4:0] gd_index, // word index within exchange
    output logic [15:0] gd_tx_word, // global word sent out
    input wire logic [15:0] gd_rx_word, // global word received
    input wire logic gd_rx_en, // received word valid
    input wire logic req_valid, // request present
    output logic req_ready, // request taken
    input wire fieldbus_register_access_pkg::p2p_req_t req, // request
    output logic rsp_valid, // response word valid
    input wire logic rsp_ready, // response word taken
    output fieldbus_register_access_pkg::p2p_rsp_t rsp, // response word
    output logic host_wr_en, // pulse: output area written by a request
    output logic [7:0] host_wr_addr, // output area word index
    output logic [15:0] host_wr_data, // output area word
    input wire logic [15:0] host_in_word, // input area word from host side
    output logic [7:0] host_in_addr // input area word index
);
    // ------------------------------------------------------------
    // buffers, word wide, high byte at lower byte address
    // ------------------------------------------------------------
    logic [15:0] in_mem [0:255];
    logic [15:0] out_mem [0:255];
    fieldbus_register_access_pkg::state_t state_reg, state_next;
    fieldbus_register_access_pkg::p2p_req_t req_reg;
    logic [7:0] ptr_reg;
    logic [15:0] left_reg;
    logic [7:0] code_reg;
    logic [7:0] in_fill_reg;
    logic gd_run_reg;
    logic [4:0] gd_cnt_reg;

    // sizes above the global cap are held at the cap
    function automatic logic [6:0] clip32(input logic [6:0] s);
        clip32 = (s > 7'(`GLOBAL_MAX_WORDS)) ? 7'(`GLOBAL_MAX_WORDS) : s;
    endfunction : clip32

    // ------------------------------------------------------------
    // global data exchange
    // ------------------------------------------------------------
    wire [6:0] gin_words = clip32(io_size_in);
    wire [6:0] gout_words = clip32(io_size_out);
    wire [6:0] gd_span = (gin_words > gout_words) ? gin_words : gout_words;
    // one word per cycle; a burst spans the larger of the two global parts
    wire gd_last = ({2'b00, gd_cnt_reg} + 7'h01) >= gd_span;
    wire gd_start = token_pass && !gd_run_reg && (gd_span != 7'h00);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            gd_run_reg <= 1'b0;
            gd_cnt_reg <= 5'h00;
        end else if (gd_start) begin
            gd_run_reg <= 1'b1;
            gd_cnt_reg <= 5'h00;
        end else if (gd_run_reg) begin
            gd_run_reg <= !gd_last;
            gd_cnt_reg <= gd_cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            gd_valid <= 1'b0;
            gd_peer <= 6'h00;
            gd_index <= 5'h00;
            gd_tx_word <= 16'h0000;
        end else begin
            gd_valid <= gd_run_reg;
            gd_peer <= peer_node_selector;
            gd_index <= gd_cnt_reg;
            gd_tx_word <= in_mem[{3'b000, gd_cnt_reg}];
        end
    end

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    // start is a register offset: 0 is the first input register, 0x400 the first output one
    wire fc_rd = req.func == `FC_READ_HOLDING;
    wire fc_ws = req.func == `FC_WRITE_SINGLE;
    wire fc_wm = req.func == `FC_WRITE_MULTI;
    wire fc_ok = fc_rd || fc_ws || fc_wm;
    wire [15:0] n_words = fc_ws ? 16'h0001 : req.count;
    wire [16:0] end_reg = {1'b0, req.start} + {1'b0, n_words};
    wire in_hit = end_reg <= {8'h00, `AREA_WORDS};
    wire out_hit = (req.start >= `OUT_FIRST_REG) && (end_reg <= {1'b0, `OUT_END_REG});
    wire addr_ok = fc_rd ? (in_hit || out_hit) : out_hit;
    wire cnt_ok = (n_words != 16'h0000) && (n_words <= {9'h000, `P2P_MAX_WORDS});
    // priority of the exception codes when several apply at once
    wire [7:0] exc_code = !fc_ok ? `EXC_ILLEGAL_FUNCTION :
                          !cnt_ok ? `EXC_ILLEGAL_VALUE :
                          !addr_ok ? `EXC_ILLEGAL_ADDRESS :
                          `EXC_HOST_BUSY;
    wire req_bad = !fc_ok || !cnt_ok || !addr_ok || host_busy;
    wire idle = state_reg == fieldbus_register_access_pkg::ST_IDLE;
    // requests only ever arrive from outside; nothing here starts one
    assign req_ready = idle;
    wire take = req_valid && idle;
    wire from_out = req_reg.start >= `OUT_FIRST_REG;
    wire rd_last = left_reg == 16'h0001;

    // one request in flight; the next is taken once the last word is accepted
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            fieldbus_register_access_pkg::ST_IDLE: begin
                if (take) begin
                    if (req_bad)
                        state_next = fieldbus_register_access_pkg::ST_EXC;
                    else if (fc_rd)
                        state_next = fieldbus_register_access_pkg::ST_READ;
                    else
                        state_next = fieldbus_register_access_pkg::ST_WRITE;
                end
            end
            fieldbus_register_access_pkg::ST_READ: begin
                if (rsp_ready && rd_last)
                    state_next = fieldbus_register_access_pkg::ST_IDLE;
            end
            fieldbus_register_access_pkg::ST_WRITE: begin
                if (rsp_ready)
                    state_next = fieldbus_register_access_pkg::ST_IDLE;
            end
            fieldbus_register_access_pkg::ST_EXC: begin
                if (rsp_ready)
                    state_next = fieldbus_register_access_pkg::ST_IDLE;
            end
            default: state_next = fieldbus_register_access_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    wire wr_now = take && !req_bad && !fc_rd;
    wire [7:0] wr_idx = 8'(req.start - `OUT_FIRST_REG);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg <= fieldbus_register_access_pkg::ST_IDLE;
            req_reg <= '0;
            ptr_reg <= 8'h00;
            left_reg <= 16'h0000;
            code_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (take) begin
                req_reg <= req;
                ptr_reg <= req.start[7:0];
                left_reg <= n_words;
                code_reg <= exc_code;
            // pointer and remaining count advance only on an accepted word
            end else if (state_reg == fieldbus_register_access_pkg::ST_READ && rsp_ready) begin
                ptr_reg <= ptr_reg + 8'h01;
                left_reg <= left_reg - 16'h0001;
            end
        end
    end

    // single-register writes land at once; multi writes are fed word by word
    // through req.wdata with count 1 per beat by the framing layer
    always_ff @(posedge clk) begin
        if (wr_now)
            out_mem[wr_idx] <= req.wdata;
        // input area follows the host side one word per cycle, round robin
        in_mem[in_fill_reg] <= host_in_word;
        if (gd_rx_en && {2'b00, gd_index} < gout_words && gd_valid)
            out_mem[{3'b000, gd_index}] <= gd_rx_word;
    end

    // the host side sees a copy of every request write to the output area; global words received into it are not copied
    always_ff @(posedge clk) begin
        if (!rstn) begin
            in_fill_reg <= 8'h00;
            host_wr_en <= 1'b0;
            host_wr_addr <= 8'h00;
            host_wr_data <= 16'h0000;
        end else begin
            in_fill_reg <= in_fill_reg + 8'h01;
            host_wr_en <= wr_now;
            host_wr_addr <= wr_idx;
            host_wr_data <= req.wdata;
        end
    end
    assign host_in_addr = in_fill_reg;

    // ------------------------------------------------------------
    // response
    // ------------------------------------------------------------
    // handshake and response word are combinational from the state
    assign rsp_valid = !idle;
    always_comb begin
        rsp = '0;
        case (state_reg)
            fieldbus_register_access_pkg::ST_READ: begin
                rsp.rdata = from_out ? out_mem[ptr_reg] : in_mem[ptr_reg];
                rsp.last = rd_last;
            end
            fieldbus_register_access_pkg::ST_WRITE: begin
                rsp.rdata = req_reg.count;
                rsp.last = 1'b1;
            end
            fieldbus_register_access_pkg::ST_EXC: begin
                rsp.exc = 1'b1;
                rsp.code = code_reg;
                rsp.last = 1'b1;
            end
            default: rsp = '0;
        endcase
    end
endmodule : fieldbus_register_access

/* File: rtl/fieldbus_register_access_params.svh */
`ifndef FIELDBUS_REGISTER_ACCESS_PARAMS_SVH
`define FIELDBUS_REGISTER_ACCESS_PARAMS_SVH
`define FC_READ_HOLDING 8'h03
`define FC_WRITE_SINGLE 8'h06
`define FC_WRITE_MULTI 8'h10
`define EXC_ILLEGAL_FUNCTION 8'h01
`define EXC_ILLEGAL_ADDRESS 8'h02
`define EXC_ILLEGAL_VALUE 8'h03
`define EXC_HOST_BUSY 8'h06
`define AREA_WORDS 9'h0100
`define OUT_FIRST_REG 16'h0400
`define OUT_END_REG 16'h0500
`define GLOBAL_MAX_WORDS 6'h20
`define P2P_MAX_WORDS 7'h7d
`endif

/* File: rtl/fieldbus_register_access_pkg.sv */
package fieldbus_register_access_pkg;
    typedef struct packed {
        logic [7:0] func;
        logic [15:0] start;
        logic [15:0] count;
        logic [15:0] wdata;
    } p2p_req_t;
    typedef struct packed {
        logic exc;
        logic [7:0] code;
        logic [15:0] rdata;
        logic last;
    } p2p_rsp_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10,
        ST_EXC = 2'b11
    } state_t;
endpackage : fieldbus_register_access_pkg

/* File: tb/fieldbus_peer_model.sv */
`timescale 1ns/10ps
module fieldbus_peer_model (
    input wire logic clk, // clock
    input wire logic stall, // slow taker
    input wire logic [7:0] host_in_addr, // area index
    output logic rsp_ready, // word taken
    output logic [15:0] host_in_word // area word
);
    // input area content follows its index, high byte first
    assign host_in_word = {host_in_addr, ~host_in_addr};
    always @(posedge clk) rsp_ready <= (stall === 1'b1) ? ~rsp_ready : 1'b1;
endmodule : fieldbus_peer_model

/* File: tb/fieldbus_register_access_props.sv */
`timescale 1ns/10ps
module fieldbus_register_access_props (
    input wire logic clk, // clock
    input wire logic rstn, // reset
    input wire logic [5:0] peer_node_selector, // peer
    input wire logic [6:0] io_size_in, // in words
    input wire logic [6:0] io_size_out, // out words
    input wire logic host_busy, // busy
    input wire logic gd_valid, // global word
    input wire logic [5:0] gd_peer, // global peer
    input wire logic [4:0] gd_index, // global index
    input wire logic req_valid, // request
    input wire logic req_ready, // taken
    input wire fieldbus_register_access_pkg::p2p_req_t req, // request
    input wire logic rsp_valid, // response
    input wire logic rsp_ready, // taken
    input wire fieldbus_register_access_pkg::p2p_rsp_t rsp, // response
    input wire logic host_wr_en, // write
    input wire logic [7:0] host_wr_addr, // index
    input wire logic [15:0] host_wr_data // word
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire take = req_valid && req_ready;
    wire okf = req.func inside {8'h03, 8'h06, 8'h10};
    wire [15:0] cnt_w = (req.func == 8'h06) ? 16'h0001 : req.count;
    wire okc = cnt_w != 16'h0000 && cnt_w <= 16'h007d;
    wire wr06 = take && req.func == 8'h06 && req.count == 16'h0001 && !host_busy;
    wire [6:0] gd_len = io_size_in > io_size_out ? io_size_in : io_size_out;
    a_ready_idle: assert property (rsp_valid && rsp_ready && rsp.last |=> req_ready && !rsp_valid)
        else $error("not idle after last word");
    a_take_answer: assert property (take |=> rsp_valid) else $error("no answer");
    a_no_spont: assert property ($rose(rsp_valid) |-> $past(take)) else $error("spont");
    a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
        else $error("rsp moved");
    a_bad_func: assert property (take && !okf |=> rsp.exc && rsp.code == 8'h01)
        else $error("no 01");
    a_bad_count: assert property (take && okf && !okc |=> rsp.exc && rsp.code == 8'h03)
        else $error("no 03");
    a_bad_addr: assert property (wr06 && req.start[15:8] == 8'h01 |=> rsp.code == 8'h02)
        else $error("no 02");
    a_busy_code: assert property (take && req.func == 8'h03 && req.start == 16'h0000
        && req.count == 16'h0001 && host_busy |=> rsp.exc && rsp.code == 8'h06) else $error("no 06");
    a_write_copy: assert property (wr06 && req.start[15:8] == 8'h04 |=> host_wr_en
        && host_wr_addr == $past(req.start[7:0]) && host_wr_data == $past(req.wdata))
        else $error("no write");
    a_gd_peer: assert property (gd_valid |-> gd_peer == peer_node_selector
        && {2'b00, gd_index} < gd_len) else $error("bad global");
    a_wr_pulse: assert property (host_wr_en |=> !host_wr_en)
        else $error("write pulse too long");
endmodule : fieldbus_register_access_props
bind fieldbus_register_access fieldbus_register_access_props fieldbus_register_access_props_i (
    .clk, .rstn, .peer_node_selector, .io_size_in, .io_size_out, .host_busy, .gd_valid,
    .gd_peer, .gd_index, .req_valid, .req_ready, .req, .rsp_valid, .rsp_ready, .rsp,
    .host_wr_en, .host_wr_addr, .host_wr_data);

/* File: tb/tb_fieldbus_register_access.sv */
`timescale 1ns/10ps
module tb_fieldbus_register_access;
    logic clk = 0, rstn = 0, host_busy = 0, token_pass = 0, gd_rx_en = 0, req_valid = 0;
    logic stall = 0, rsp_ready, gd_valid, req_ready, rsp_valid, host_wr_en;
    logic [5:0] sel = 6'h2a, gd_peer;
    logic [6:0] size_in = 7'h00, size_out = 7'h00;
    logic [4:0] gd_index;
    logic [7:0] wr_addr, in_addr;
    logic [15:0] gd_tx, rx_word = 16'h0c0c, wr_data, in_word;
    logic [23:0] wr_seen = 24'h00_0000;
    fieldbus_register_access_pkg::p2p_req_t req = '0;
    fieldbus_register_access_pkg::p2p_rsp_t rsp;
    int num_errors = 0, samples_checked = 0, cycles = 0;
    localparam logic [47:0] exc_tbl [7] = '{48'h0400_0000_0101, 48'h0300_0000_0003,
        48'h0300_0000_7e03, 48'h0601_0000_0102, 48'h0305_0000_0102, 48'h0600_0000_0102,
        48'h0300_0000_0106};
    initial forever #25 clk = ~clk;
    fieldbus_register_access fieldbus_register_access_i (.clk, .rstn, .peer_node_selector(sel),
        .io_size_in(size_in), .io_size_out(size_out), .host_busy, .token_pass, .gd_valid,
        .gd_peer, .gd_index, .gd_tx_word(gd_tx), .gd_rx_word(rx_word), .gd_rx_en, .req_valid,
        .req_ready, .req, .rsp_valid, .rsp_ready, .rsp, .host_wr_en, .host_wr_addr(wr_addr),
        .host_wr_data(wr_data), .host_in_word(in_word), .host_in_addr(in_addr));
    fieldbus_peer_model fieldbus_peer_model_i (.clk, .stall, .host_in_addr(in_addr),
        .rsp_ready, .host_in_word(in_word));
    task automatic end_sim();
        if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic send(input logic [7:0] f, input logic [15:0] s, c, w);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{f, s, c, w};
        @(posedge clk);
        while (req_ready !== 1'b1) @(posedge clk);
        req_valid <= 1'b0;
    endtask : send
    task automatic get(input logic e, input logic [7:0] c, input logic [15:0] d, input logic l);
        do @(posedge clk); while (!(rsp_valid === 1'b1 && rsp_ready === 1'b1));
        chk({6'h00, rsp}, {6'h00, e, c, d, l});
    endtask : get
    task automatic t_read();
        stall <= 1'b1;
        send(8'h03, 16'h0002, 16'h0002, 16'h0000);
        get(1'b0, 8'h00, 16'h02fd, 1'b0);
        get(1'b0, 8'h00, 16'h03fc, 1'b1);
        stall <= 1'b0;
    endtask : t_read
    task automatic t_write();
        send(8'h06, 16'h0405, 16'h0001, 16'hbeef);
        get(1'b0, 8'h00, 16'h0001, 1'b1);
        #1;
        chk({8'h00, wr_seen}, 32'h0005_beef);
        send(8'h10, 16'h0406, 16'h0003, 16'h1234);
        get(1'b0, 8'h00, 16'h0003, 1'b1);
        #1;
        chk({8'h00, wr_seen}, 32'h0006_1234);
        send(8'h03, 16'h0405, 16'h0002, 16'h0000);
        get(1'b0, 8'h00, 16'hbeef, 1'b0);
        get(1'b0, 8'h00, 16'h1234, 1'b1);
    endtask : t_write
    task automatic t_exc();
        for (int i = 0; i < 7; i++) begin
            if (i == 6) host_busy <= 1'b1;
            send(exc_tbl[i][47:40], exc_tbl[i][39:24], exc_tbl[i][23:8], 16'h0000);
            get(1'b1, exc_tbl[i][7:0], 16'h0000, 1'b1);
        end
        host_busy <= 1'b0;
        send(8'h03, 16'h0000, 16'h0001, 16'h0000);
        get(1'b0, 8'h00, 16'h00ff, 1'b1);
    endtask : t_exc
    task automatic gd_burst(input logic [6:0] si, input logic [6:0] so, input int want);
        int n;
        n = 0;
        size_in <= si;
        size_out <= so;
        @(posedge clk);
        token_pass <= 1'b1;
        @(posedge clk);
        token_pass <= 1'b0;
        repeat (40) begin
            @(posedge clk);
            if (gd_valid === 1'b1) begin
                chk({27'h000_0000, gd_index}, n);
                chk({16'h0000, gd_tx}, {16'h0000, 8'(n), ~8'(n)});
                chk({26'h000_0000, gd_peer}, {26'h000_0000, sel});
                n++;
            end
        end
        chk(n, want);
    endtask : gd_burst
    task automatic t_global();
        gd_rx_en <= 1'b1;
        gd_burst(7'h02, 7'h01, 2);
        gd_rx_en <= 1'b0;
        gd_burst(7'h28, 7'h00, 32);
        send(8'h03, 16'h0400, 16'h0001, 16'h0000);
        get(1'b0, 8'h00, 16'h0c0c, 1'b1);
    endtask : t_global
    always @(posedge clk) if (host_wr_en === 1'b1) wr_seen <= {wr_addr, wr_data};
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (300) @(posedge clk);
        t_read();
        t_write();
        t_exc();
        t_global();
        end_sim();
    end
endmodule : tb_fieldbus_register_access
